// >>> core/ptm_pkg.sv
package ptm_pkg;
  localparam logic [1:0] PTM_MODE_DUAL8 = 2'h0;
  localparam logic [1:0] PTM_MODE_CASC16 = 2'h1;
  localparam logic [1:0] PTM_MODE_PULSE = 2'h2;
  localparam logic [1:0] PTM_MODE_PWM = 2'h3;
  localparam logic [1:0] PTM_PWM_N6 = 2'h1;
  localparam logic [1:0] PTM_PWM_N7 = 2'h2;
  localparam logic [1:0] PTM_PWM_N8 = 2'h3;
  localparam logic [7:0] PTM_TOP_N6 = 8'h3F;
  localparam logic [7:0] PTM_TOP_N7 = 8'h7F;
  localparam logic [7:0] PTM_TOP_N8 = 8'hFF;
  localparam logic [7:0] PTM_ZERO = 8'h00;
  localparam logic [7:0] PTM_ONE = 8'h01;
  localparam logic [1:0] PTM_USEL_MATCH = 2'h0;
  localparam logic [1:0] PTM_TFF_INV = 2'h0;
  localparam logic [1:0] PTM_TFF_CLR = 2'h1;
  localparam logic [1:0] PTM_TFF_SET = 2'h2;

  // Clock taps for one pair: lower select indexes 0..3, upper 1..3 (upper select 0 picks the lower match)
  typedef struct packed {
    logic [3:0] lower_tick;
    logic [3:0] upper_tick;
  } ptm_ticks_t;

  // Configuration of one pair
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] lower_sel;
    logic [1:0] upper_sel;
    logic [1:0] pwm_cycle;
    logic run_lower;
    logic run_upper;
    logic tff_inv_en;
  } ptm_cfg_t;

  // Compare register write strobes with data
  typedef struct packed {
    logic wr_lower;
    logic wr_upper;
    logic [7:0] wdata;
  } ptm_wr_t;
endpackage : ptm_pkg

// >>> core/ptm_timer.sv
`timescale 1ns/1ns
`default_nettype none
module ptm_timer
  import ptm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Count taps, already synchronous one-cycle pulses
  input wire ptm_ticks_t ticks_a_i,
  input wire ptm_ticks_t ticks_b_i,
  // Configuration
  input wire ptm_cfg_t cfg_a_i,
  input wire ptm_cfg_t cfg_b_i,
  input wire logic compare_dbuf_enable_i,
  input wire logic pulse_active_high_i,
  // Toggle flip-flop software control
  input wire logic tff_a_wr_i,
  input wire logic [1:0] tff_a_cmd_i,
  input wire logic tff_b_wr_i,
  input wire logic [1:0] tff_b_cmd_i,
  // Compare writes
  input wire ptm_wr_t wr_a_i,
  input wire ptm_wr_t wr_b_i,
  // Status
  output logic [3:0] irq_o,
  output logic [7:0] lower_counter_a_o,
  output logic [7:0] lower_counter_b_o,
  output logic [7:0] upper_counter_b_o,
  output logic first_pair_toggle_ff_o,
  output logic timer_output_pin_o
);
  logic [7:0] lc_a_q, uc_a_q, lc_b_q, uc_b_q;
  logic [7:0] cl_a_q, cu_a_q, cl_b_q, cu_b_q, buf_b_q;
  logic cmp_en_a_q, cmp_en_b_q;
  logic tff_a_q, tff_b_q, pulse_q;
  logic [3:0] irq_q;
  logic [7:0] pwm_top;

  // Lower-match, upper-match and overflow per pair
  logic ml_a, mu_a, ml_b, mu_b, ovl_a, ovl_b;
  logic tl_a, tu_a, tl_b, tu_b, clr_l_a, clr_u_a, clr_l_b, clr_u_b;
  logic casc_a, casc_b, ppg_b, pwm_b, both_a, both_b, pwm_wrap;

  assign casc_a = (cfg_a_i.mode == PTM_MODE_CASC16);
  assign casc_b = (cfg_b_i.mode == PTM_MODE_CASC16);
  // Pulse and PWM live only on the second pair; pair A treats them as dual 8-bit
  assign ppg_b = (cfg_b_i.mode == PTM_MODE_PULSE);
  assign pwm_b = (cfg_b_i.mode == PTM_MODE_PWM);

  always_comb begin
    case (cfg_b_i.pwm_cycle)
      PTM_PWM_N6: pwm_top = PTM_TOP_N6;
      PTM_PWM_N7: pwm_top = PTM_TOP_N7;
      PTM_PWM_N8: pwm_top = PTM_TOP_N8;
      default: pwm_top = PTM_TOP_N8;
    endcase
  end

  assign tl_a = cfg_a_i.run_lower && ticks_a_i.lower_tick[cfg_a_i.lower_sel];
  assign tl_b = cfg_b_i.run_lower && ticks_b_i.lower_tick[cfg_b_i.lower_sel];
  // Compare value 00 matches on overflow, i.e. counter wraps through zero
  assign ml_a = tl_a && (lc_a_q + PTM_ONE == cl_a_q);
  assign ml_b = tl_b && (lc_b_q + PTM_ONE == cl_b_q);
  assign ovl_a = tl_a && (lc_a_q == PTM_TOP_N8);
  assign ovl_b = tl_b && (lc_b_q == PTM_TOP_N8);
  // Wrap on reaching 2^n-1 so the period is 2^n-1 ticks, not 2^n
  assign pwm_wrap = pwm_b && tl_b && (lc_b_q + PTM_ONE == pwm_top);

  assign tu_a = cfg_a_i.run_upper && (casc_a ? ovl_a :
    (cfg_a_i.upper_sel == PTM_USEL_MATCH ? ml_a :
     ticks_a_i.upper_tick[cfg_a_i.upper_sel]));
  assign tu_b = cfg_b_i.run_upper && !ppg_b && (casc_b ? ovl_b :
    (cfg_b_i.upper_sel == PTM_USEL_MATCH ? ml_b :
     ticks_b_i.upper_tick[cfg_b_i.upper_sel]));
  assign mu_a = tu_a && (uc_a_q + PTM_ONE == cu_a_q);
  assign mu_b = tu_b && (uc_b_q + PTM_ONE == cu_b_q);

  // In cascade the pair matches when the 16-bit value reaches both compares
  assign both_a = casc_a && cmp_en_a_q && tl_a && (lc_a_q + PTM_ONE == cl_a_q) &&
    (uc_a_q == cu_a_q);
  assign both_b = casc_b && cmp_en_b_q && tl_b && (lc_b_q + PTM_ONE == cl_b_q) &&
    (uc_b_q == cu_b_q);

  logic ppg_hit_l, ppg_hit_u;
  assign ppg_hit_l = ppg_b && tl_b && (lc_b_q + PTM_ONE == cl_b_q);
  assign ppg_hit_u = ppg_b && tl_b && (lc_b_q + PTM_ONE == cu_b_q);

  // Counter clears: cascade lower clears only on joint match
  assign clr_l_a = casc_a ? both_a : ml_a;
  assign clr_u_a = casc_a ? both_a : mu_a;
  assign clr_l_b = casc_b ? both_b : (pwm_b ? pwm_wrap :
    (ppg_b ? ppg_hit_u : ml_b));
  assign clr_u_b = casc_b ? both_b : mu_b;

  logic irq_u_a, irq_u_b;
  assign irq_u_a = casc_a ? both_a : mu_a;
  assign irq_u_b = casc_b ? both_b : mu_b;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || !cfg_a_i.run_lower) begin
      lc_a_q <= PTM_ZERO;
    end else if (clr_l_a) begin
      lc_a_q <= PTM_ZERO;
    end else if (tl_a) begin
      lc_a_q <= lc_a_q + PTM_ONE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || !cfg_a_i.run_upper) begin
      uc_a_q <= PTM_ZERO;
    end else if (clr_u_a) begin
      uc_a_q <= PTM_ZERO;
    end else if (tu_a) begin
      uc_a_q <= uc_a_q + PTM_ONE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || !cfg_b_i.run_lower) begin
      lc_b_q <= PTM_ZERO;
    end else if (clr_l_b) begin
      lc_b_q <= PTM_ZERO;
    end else if (tl_b) begin
      lc_b_q <= lc_b_q + PTM_ONE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || !cfg_b_i.run_upper) begin
      uc_b_q <= PTM_ZERO;
    end else if (clr_u_b) begin
      uc_b_q <= PTM_ZERO;
    end else if (tu_b) begin
      uc_b_q <= uc_b_q + PTM_ONE;
    end
  end

  // Compare registers of pair A and comparator suspend
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cl_a_q <= PTM_ZERO;
      cu_a_q <= PTM_ZERO;
      cmp_en_a_q <= 1'b1;
    end else begin
      if (wr_a_i.wr_lower) begin
        cl_a_q <= wr_a_i.wdata;
      end
      if (wr_a_i.wr_upper) begin
        cu_a_q <= wr_a_i.wdata;
      end
      if (wr_a_i.wr_upper) begin
        cmp_en_a_q <= 1'b1;
      end else if (wr_a_i.wr_lower && casc_a) begin
        cmp_en_a_q <= 1'b0;
      end
    end
  end

  // Pair B: lower compare is double buffered
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cl_b_q <= PTM_ZERO;
      buf_b_q <= PTM_ZERO;
      cu_b_q <= PTM_ZERO;
      cmp_en_b_q <= 1'b1;
    end else begin
      if (wr_b_i.wr_lower) begin
        buf_b_q <= wr_b_i.wdata;
      end
      // A same-cycle buffer transfer wins over a software write in buffered mode; the write stays in the buffer
      if (wr_b_i.wr_lower && !compare_dbuf_enable_i) begin
        cl_b_q <= wr_b_i.wdata;
      end else if (compare_dbuf_enable_i && (ppg_hit_u || pwm_wrap)) begin
        cl_b_q <= buf_b_q;
      end
      if (wr_b_i.wr_upper) begin
        cu_b_q <= wr_b_i.wdata;
      end
      if (wr_b_i.wr_upper) begin
        cmp_en_b_q <= 1'b1;
      end else if (wr_b_i.wr_lower && casc_b) begin
        cmp_en_b_q <= 1'b0;
      end
    end
  end

  // Toggle flip-flops sit only in the upper timers
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      tff_a_q <= 1'b0;
    end else if (tff_a_wr_i && tff_a_cmd_i == PTM_TFF_CLR) begin
      tff_a_q <= 1'b0;
    end else if (tff_a_wr_i && tff_a_cmd_i == PTM_TFF_SET) begin
      tff_a_q <= 1'b1;
    end else if ((tff_a_wr_i && tff_a_cmd_i == PTM_TFF_INV) ^
                 (cfg_a_i.tff_inv_en && irq_u_a)) begin
      tff_a_q <= !tff_a_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      tff_b_q <= 1'b0;
    end else if (tff_b_wr_i && tff_b_cmd_i == PTM_TFF_CLR) begin
      tff_b_q <= 1'b0;
    end else if (tff_b_wr_i && tff_b_cmd_i == PTM_TFF_SET) begin
      tff_b_q <= 1'b1;
    end else if ((tff_b_wr_i && tff_b_cmd_i == PTM_TFF_INV) ^
                 (cfg_b_i.tff_inv_en && irq_u_b)) begin
      tff_b_q <= !tff_b_q;
    end
  end

  // Waveform of pulse and PWM modes; idles at the inactive level
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || !(ppg_b || pwm_b) || !cfg_b_i.run_lower) begin
      pulse_q <= 1'b0;
    end else if (ppg_hit_l ^ ppg_hit_u) begin
      pulse_q <= !pulse_q;
    end else if (pwm_b && tl_b && ((lc_b_q + PTM_ONE == cl_b_q) ^ pwm_wrap)) begin
      pulse_q <= !pulse_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irq_q <= 4'h0;
    end else begin
      irq_q <= {irq_u_b, (casc_b ? 1'b0 : (pwm_b ? pwm_wrap : ml_b)),
                irq_u_a, (casc_a ? 1'b0 : ml_a)};
    end
  end

  assign irq_o = irq_q;
  assign lower_counter_a_o = lc_a_q;
  assign lower_counter_b_o = lc_b_q;
  assign upper_counter_b_o = uc_b_q;
  assign first_pair_toggle_ff_o = tff_a_q;
  assign timer_output_pin_o = (ppg_b || pwm_b) ? (pulse_q ^ !pulse_active_high_i) :
    tff_b_q;

  a_casc_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    both_b && cfg_b_i.run_lower && cfg_b_i.run_upper |=> lc_b_q == PTM_ZERO && uc_b_q == PTM_ZERO)
    else $error("cascade joint match did not clear counters");
  a_casc_irq: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    both_b |=> irq_o[3])
    else $error("cascade joint match gave no irq");
  a_casc_noclr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    casc_b && ml_b && !both_b && cfg_b_i.run_lower |=> lc_b_q == cl_b_q)
    else $error("cascade lower match cleared counter");
  a_cmp_suspend: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    casc_b && wr_b_i.wr_lower && !wr_b_i.wr_upper |=> !cmp_en_b_q)
    else $error("comparator not suspended");
  a_cmp_resume: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_b_i.wr_upper |=> cmp_en_b_q)
    else $error("comparator not restarted");
  a_pwm_wrap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pwm_wrap && cfg_b_i.run_lower |=> lc_b_q == PTM_ZERO)
    else $error("pwm counter not cleared at wrap");
  a_dbuf_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    compare_dbuf_enable_i && pwm_wrap && !wr_b_i.wr_lower |=> cl_b_q == $past(buf_b_q))
    else $error("buffer not transferred at wrap");
  a_dbuf_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    compare_dbuf_enable_i && wr_b_i.wr_lower && !ppg_hit_u && !pwm_wrap |=> cl_b_q == $past(cl_b_q))
    else $error("buffered write reached active compare");
  a_direct_wr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !compare_dbuf_enable_i && wr_b_i.wr_lower |=> cl_b_q == $past(wr_b_i.wdata) && buf_b_q == cl_b_q)
    else $error("unbuffered write not in both registers");
  a_ppg_toggle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ppg_hit_l ^ ppg_hit_u) && cfg_b_i.run_lower && ppg_b ##1 ppg_b && cfg_b_i.run_lower
    |-> pulse_q != $past(pulse_q))
    else $error("pulse output did not invert");

  c_casc: cover property (@(posedge clk_sys_i) both_b);
  c_ppg: cover property (@(posedge clk_sys_i) ppg_hit_u && compare_dbuf_enable_i);
  c_pwm: cover property (@(posedge clk_sys_i) pwm_wrap && cfg_b_i.pwm_cycle == PTM_PWM_N7);
  c_dual: cover property (@(posedge clk_sys_i) mu_a && cfg_a_i.upper_sel == PTM_USEL_MATCH);
endmodule : ptm_timer
`default_nettype wire

// >>> bench/ptm_testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ptm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  ptm_ticks_t ta, tb;
  ptm_cfg_t ca, cb;
  ptm_wr_t wa, wb;
  logic dbuf, pah, tawr, tbwr, tffa, pin, pexp;
  logic [1:0] tacmd, tbcmd;
  logic [3:0] irq;
  logic [7:0] la, lb, ub, mcnt, mlo, mhi, mbuf;
  int mismatches = 0;
  int num_checks = 0;

  ptm_timer DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ticks_a_i(ta), .ticks_b_i(tb),
    .cfg_a_i(ca), .cfg_b_i(cb), .compare_dbuf_enable_i(dbuf), .pulse_active_high_i(pah),
    .tff_a_wr_i(tawr), .tff_a_cmd_i(tacmd), .tff_b_wr_i(tbwr), .tff_b_cmd_i(tbcmd),
    .wr_a_i(wa), .wr_b_i(wb), .irq_o(irq), .lower_counter_a_o(la), .lower_counter_b_o(lb),
    .upper_counter_b_o(ub), .first_pair_toggle_ff_o(tffa), .timer_output_pin_o(pin));

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Inputs change 1 ns after the edge so the design never races the bench
  task automatic cyc();
    @(posedge clk_sys_i);
    #1;
  endtask : cyc

  function automatic ptm_cfg_t mk(input logic [1:0] m, input logic [1:0] ls,
    input logic [1:0] us, input logic [1:0] pc, input logic iv);
    return '{m, ls, us, pc, 1'b0, 1'b0, iv};
  endfunction : mk

  function automatic logic [7:0] pwm_top(input logic [1:0] c);
    case (c)
      PTM_PWM_N6: return PTM_TOP_N6;
      PTM_PWM_N7: return PTM_TOP_N7;
      default: return PTM_TOP_N8;
    endcase
  endfunction : pwm_top

  task automatic wr(input logic b, input logic up, input logic [7:0] v);
    ptm_wr_t w;
    w = '{!up, up, v};
    if (b) wb = w;
    else wa = w;
    cyc();
    wa = '0;
    wb = '0;
    cyc();
  endtask : wr

  task automatic dual8();
    logic [1:0] s, up;
    logic [7:0] l, u;
    s = 2'($urandom);
    l = 8'(2 + $urandom % 5);
    u = 8'(2 + $urandom % 3);
    ca = mk(PTM_MODE_DUAL8, s, PTM_USEL_MATCH, 2'h0, 1'b1);
    cb = mk(PTM_MODE_DUAL8, s, PTM_USEL_MATCH, 2'h0, 1'b0);
    wr(0, 0, l);
    wr(0, 1, u);
    wr(1, 0, l);
    wr(1, 1, u);
    {ca.run_lower, ca.run_upper, cb.run_lower, cb.run_upper} = 4'hF;
    cyc();
    for (int k = 1; k <= int'(u); k++) begin
      for (int i = 0; i < int'(l); i++) begin
        ta = '{4'h1 << s, 4'($urandom)};
        tb = ta;
        cyc();
        chk(la, 8'((i + 1) % l));
        chk(lb, 8'((i + 1) % l));
      end
      ta = '0;
      tb = '0;
      chk({irq[2], irq[0]}, 2'b11);
      up = {irq[3], irq[1]};
      cyc();
      up |= {irq[3], irq[1]};
      cyc();
      up |= {irq[3], irq[1]};
      chk(up, (k == int'(u)) ? 2'b11 : 2'b00);
      chk(ub, 8'(k % u));
      chk(tffa, k == int'(u));
      chk(pin, 1'b0);
    end
    $display("Dual 8-bit test done");
  endtask : dual8

  task automatic tffcmd();
    logic [1:0] cmds [4] = '{PTM_TFF_CLR, PTM_TFF_SET, PTM_TFF_INV, 2'h3};
    logic exps [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    for (int j = 0; j < 4; j++) begin
      {tawr, tbwr, tacmd, tbcmd} = {2'b11, cmds[j], cmds[j]};
      cyc();
      chk({tffa, pin}, {2{exps[j]}});
    end
    {tawr, tbwr} = 2'b00;
    $display("Toggle command test done");
  endtask : tffcmd

  task automatic casc(input int n, input bit clr);
    logic [15:0] e;
    for (int i = 0; i < n; i++) begin
      tb = '{4'h1 << cb.lower_sel, 4'($urandom)};
      cyc();
      e = (clr && i + 1 == n) ? 16'h0000 : 16'(i + 1);
      if (clr && i + 1 == n) pexp = ~pexp;
      chk(lb, e[7:0]);
      chk(ub, e[15:8]);
      chk(irq[3], clr && i + 1 == n);
      chk(pin, pexp);
    end
    tb = '0;
  endtask : casc

  task automatic cascade();
    logic [7:0] cl;
    cb = mk(PTM_MODE_CASC16, 2'($urandom), 2'h1, 2'h0, 1'b1);
    cl = 8'(1 + $urandom % 8);
    wr(1, 0, cl);
    wr(1, 1, PTM_ONE);
    {cb.run_lower, cb.run_upper} = 2'b11;
    cyc();
    pexp = 1'b0;
    casc(256 + cl, 1);
    wr(1, 0, cl);
    casc(256 + cl, 0);
    wr(1, 1, PTM_ONE);
    {cb.run_lower, cb.run_upper} = 2'b00;
    cyc();
    {cb.run_lower, cb.run_upper} = 2'b11;
    cyc();
    casc(256 + cl, 1);
    $display("Cascade test done");
  endtask : cascade

  // Pin level depends on the active-level input, so only its toggles are judged
  task automatic run_b(input int n, input bit pwm, input int at, input logic [7:0] v);
    logic t, p, h1, h2;
    ptm_ticks_t tk;
    for (int i = 0; i < n; i++) begin
      p = pin;
      t = (i != at) && ($urandom % 2 == 1);
      tk = '{4'($urandom), 4'($urandom)};
      tk.lower_tick[cb.lower_sel] = t;
      tb = tk;
      if (i == at) begin
        wb = '{1'b1, 1'b0, v};
        mbuf = v;
        if (!dbuf) mlo = v;
      end
      cyc();
      wb = '0;
      h1 = t && (mcnt + 8'h01 == mlo);
      h2 = t && (mcnt + 8'h01 == (pwm ? pwm_top(cb.pwm_cycle) : mhi));
      mcnt = !t ? mcnt : h2 ? PTM_ZERO : mcnt + 8'h01;
      if (h2 && dbuf) mlo = mbuf;
      chk(lb, mcnt);
      chk(pin ^ p, h1 || h2);
      if (pwm) chk(irq[2], h2);
      else chk(ub, PTM_ZERO);
    end
    // A tick left standing would advance the counter behind the model's back
    tb = '0;
  endtask : run_b

  task automatic pulse_pwm();
    logic [7:0] top;
    pah = 1'($urandom);
    dbuf = 1'b0;
    cb = mk(PTM_MODE_PULSE, 2'($urandom), 2'h1, 2'h0, 1'b0);
    mlo = 8'(1 + $urandom % 20);
    mhi = mlo + 8'(1 + $urandom % 20);
    wr(1, 0, mlo);
    wr(1, 1, mhi);
    {mbuf, mcnt} = {mlo, PTM_ZERO};
    {cb.run_lower, cb.run_upper} = 2'b11;
    cyc();
    run_b(200, 0, -1, PTM_ZERO);
    dbuf = 1'b1;
    cyc();
    run_b(200, 0, 10, 8'(1 + $urandom % (mhi - 1)));
    $display("Pulse test done");
    for (int k = 0; k < 3; k++) begin
      top = pwm_top(2'(k + 1));
      pah = 1'($urandom);
      dbuf = 1'b0;
      cb = mk(PTM_MODE_PWM, 2'($urandom), 2'h1, 2'(k + 1), 1'b0);
      mlo = 8'(1 + $urandom % (top - 1));
      wr(1, 0, mlo);
      {mbuf, mcnt, dbuf} = {mlo, PTM_ZERO, 1'(k)};
      {cb.run_lower, cb.run_upper} = 2'b11;
      cyc();
      run_b(4 * top, 1, 7, 8'(1 + $urandom % (top - 1)));
    end
    $display("PWM test done");
  endtask : pulse_pwm

  initial begin
    {ta, tb, ca, cb, wa, wb} = '0;
    {dbuf, pah, tawr, tbwr, tacmd, tbcmd} = 8'h40;
    void'($urandom(20993));
    repeat (8) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    cyc();
    chk({irq, la[3:0]}, 8'h00);
    chk(lb, PTM_ZERO);
    dual8();
    tffcmd();
    cascade();
    pulse_pwm();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
